/* rtl/lmr_liu_ctrl.sv */
// liu mode control, master clock choice and receive framer interface
// Function
// - pin strap high: config from pins, status on pins, registers refused.
// - pin strap low: processor bus mode, parallel bus by default.
// - serial bus only when style, read, write low and latch enable high.
// - register bits mirror pin functions but are always active high.
// - configs live in both modes take the or of pin and register.
// - ds3 uses its own ref, else (unless it is held high) e3 then sonet, else transmit clock.
// - e3 uses its own ref, else (unless it is held high) ds3 then sonet, else transmit clock.
// - sonet uses its own ref, else (unless it is held high) ds3 then e3, else transmit clock.
// - master ref pins are inputs in pin mode, two-way in bus mode.
// - global float input low floats receive, loss, master ref and transmit driver outputs.
// - asynchronous low reset clears logic and registers while held.
// - scan shifts in on rising, out on falling, tap reset async.
// - receive clock is recovered clock, master clock during signal loss.
// - receive data changes on falling clock edge, rising when flipped.
// - bipolar mode pulses plus and minus outputs per line pulse.
// - binary mode gives decoded data and pulses violation output.
// - receive float input low floats that port's clock and data.
// - signal loss asserts after a long run of consecutive zeros.
// - signal loss clears after a long span without excessive zeros.
// - excessive zeros: three in ds3 and sonet, four in e3.
// - rate selects pick ds3, else e3 or sonet by second select.
`include "lmr_cfg.svh"

module lmr_liu_ctrl
    import lmr_pkg::*;
(
    // clock, reset, enable
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hclk_en,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // mode straps and legacy bus select pins
    input wire logic pin_config_select,
    input wire logic bus_style_select,
    input wire logic rd_strobe_n,
    input wire logic wr_strobe_n,
    input wire logic addr_latch_en,
    output logic [1:0] iface_mode,
    // hardware-mode configuration pins
    input wire logic european_rate_select,
    input wire logic sonet_rate_select,
    input wire logic rx_edge_flip,
    input wire logic rx_nrz_select,
    input wire logic rx_float_n,
    input wire logic tx_driver_float_n,
    input wire logic all_outputs_float_n,
    output logic tx_driver_float,
    // master reference pins and transmit clock
    input wire logic ds3_master_ref_i,
    output logic ds3_master_ref_o,
    output logic ds3_master_ref_oe,
    input wire logic e3_master_ref_i,
    output logic e3_master_ref_o,
    output logic e3_master_ref_oe,
    input wire logic sonet_master_ref_i,
    output logic sonet_master_ref_o,
    output logic sonet_master_ref_oe,
    input wire logic tx_line_clock,
    // receive path from clock recovery and to the framer
    input wire logic rx_rec_clock,
    input wire logic rx_line_plus,
    input wire logic rx_line_minus,
    output logic rx_clock_o,
    output logic rx_clock_oe,
    output logic rx_plus_or_data_o,
    output logic rx_plus_or_data_oe,
    output logic rx_minus_or_violation_o,
    output logic rx_minus_or_violation_oe,
    output logic rx_signal_absent_n_o,
    output logic rx_signal_absent_n_oe,
    // boundary scan
    input wire logic scan_clock,
    input wire logic scan_reset_n,
    input wire logic scan_mode_sel,
    input wire logic scan_in,
    output logic scan_out,
    output logic scan_out_oe
);

    lmr_st_t st_ff, nxt_st;

    logic bus, euro, sonet, flip, nrz, tick, mark, viol, exz;
    logic rise, fall, upd, mref, hit, rx_flt;
    logic [3:0] refs, act;
    logic [7:0] thr, nz, nc;
    lmr_rate_t rate;

    function automatic logic [7:0] sat_inc(input logic [7:0] v);
        return (v == 8'hff) ? v : v + 8'h01;
    endfunction

    // priority: own ref, then the two others in order unless own ref is held high, else transmit clock
    function automatic lmr_src_t sel_src(input lmr_rate_t r,
                                         input logic [3:0] a,
                                         input logic [3:0] lvl);
        lmr_src_t p, a1, a2;
        p = SRC_DS3;
        a1 = SRC_E3;
        a2 = SRC_STS;
        if (r == RATE_E3) begin
            p = SRC_E3;
            a1 = SRC_DS3;
        end else if (r == RATE_STS) begin
            p = SRC_STS;
            a1 = SRC_DS3;
            a2 = SRC_E3;
        end
        if (a[p]) begin
            return p;
        end
        // the rate's own ref held high asks for the transmit clock outright
        if (lvl[p]) begin
            return SRC_TX;
        end
        if (a[a1]) begin
            return a1;
        end
        if (a[a2]) begin
            return a2;
        end
        return SRC_TX;
    endfunction

    always_comb begin
        nxt_st = st_ff;
        // every strap, reference and line pin passes two flops before use
        nxt_st.s1 = lmr_pins_t'({ds3_master_ref_i, e3_master_ref_i,
            sonet_master_ref_i, tx_line_clock, rx_rec_clock, rx_line_plus,
            rx_line_minus, pin_config_select, bus_style_select, rd_strobe_n,
            wr_strobe_n, addr_latch_en, european_rate_select,
            sonet_rate_select, rx_edge_flip, rx_nrz_select, rx_float_n,
            tx_driver_float_n, all_outputs_float_n});
        nxt_st.s2 = st_ff.s1;

        // mode and effective configuration
        bus = ~st_ff.s2.pin_cfg;
        if (!bus) begin
            nxt_st.ifm = IF_PIN;
        end else if (!st_ff.s2.bus_style && !st_ff.s2.rd_n &&
                     !st_ff.s2.wr_n && st_ff.s2.ale) begin
            nxt_st.ifm = IF_SPI;
        end else begin
            nxt_st.ifm = IF_PAR;
        end
        euro = bus ? st_ff.ctrl[`LMR_C_EURO] : st_ff.s2.euro;
        sonet = bus ? st_ff.ctrl[`LMR_C_SONET] : st_ff.s2.sonet;
        flip = bus ? st_ff.ctrl[`LMR_C_FLIP] : st_ff.s2.flip;
        nrz = bus ? st_ff.ctrl[`LMR_C_NRZ] : st_ff.s2.nrz;
        if (!euro) begin
            rate = RATE_DS3;
        end else if (sonet) begin
            rate = RATE_STS;
        end else begin
            rate = RATE_E3;
        end

        // reference activity, a stopped ref reads as idle
        refs = {st_ff.s2.tx_clk, st_ff.s2.mref_sts, st_ff.s2.mref_e3,
                st_ff.s2.mref_ds3};
        nxt_st.ref_prev = refs;
        for (int i = 0; i < 4; i++) begin
            act[i] = st_ff.act_cnt[i] < `LMR_ACT_WIN;
            nxt_st.act_cnt[i] = (refs[i] != st_ff.ref_prev[i]) ? 8'h00
                                : sat_inc(st_ff.act_cnt[i]);
        end
        nxt_st.src = sel_src(rate, act, refs);
        mref = refs[st_ff.src];

        // one bit per rising edge of the recovered clock
        tick = st_ff.s2.rx_clk & ~st_ff.rx_prev;
        nxt_st.rx_prev = st_ff.s2.rx_clk;
        mark = st_ff.s2.rx_pos | st_ff.s2.rx_neg;
        // two marks of one polarity in a row break alternation
        viol = mark & (st_ff.s2.rx_neg == st_ff.last_neg);
        thr = (rate == RATE_E3) ? `LMR_EXZ_E3 : `LMR_EXZ_DS3;
        nz = mark ? 8'h00 : sat_inc(st_ff.zero_run);
        exz = nz >= thr;
        nc = exz ? 8'h00 : sat_inc(st_ff.clear_run);
        if (tick) begin
            nxt_st.zero_run = nz;
            nxt_st.clear_run = nc;
            if (mark) begin
                nxt_st.last_neg = st_ff.s2.rx_neg;
            end
            if (nz == `LMR_LOS_SET) begin
                nxt_st.los = 1'b1;
            end else if (st_ff.los && nc == `LMR_LOS_CLR) begin
                nxt_st.los = 1'b0;
            end
            nxt_st.bit_a = nrz ? mark : st_ff.s2.rx_pos;
            nxt_st.bit_b = nrz ? viol : st_ff.s2.rx_neg;
        end

        // outgoing clock, data moves on the chosen edge of it
        nxt_st.rclk_o = st_ff.los ? mref : st_ff.s2.rx_clk;
        rise = nxt_st.rclk_o & ~st_ff.rclk_o;
        fall = ~nxt_st.rclk_o & st_ff.rclk_o;
        upd = flip ? rise : fall;
        if (upd) begin
            nxt_st.da_o = st_ff.bit_a;
            nxt_st.db_o = st_ff.bit_b;
        end

        // output enables; the receiver keeps running while floated
        rx_flt = ~st_ff.s2.rx_flt_n | (bus & st_ff.ctrl[`LMR_C_RXFLT]);
        nxt_st.rx_oe = st_ff.s2.hiz_n & ~rx_flt;
        nxt_st.los_n_o = ~st_ff.los;
        nxt_st.los_oe = st_ff.los & st_ff.s2.hiz_n;
        nxt_st.tx_flt = ~st_ff.s2.tx_flt_n | ~st_ff.s2.hiz_n |
                        (bus & st_ff.ctrl[`LMR_C_TXFLT]);
        nxt_st.mref_o = mref;
        for (int i = 0; i < 3; i++) begin
            // only a ref pin nobody is driving may carry our clock out
            nxt_st.mref_oe[i] = bus & st_ff.ctrl[`LMR_C_MDRV] &
                                st_ff.s2.hiz_n & ~act[i];
        end

        // ahb-lite: zero wait states, always okay
        nxt_st.rdy = 1'b1;
        hit = hsel & htrans[1] & hready & bus & (haddr[31:8] == 24'h0);
        nxt_st.ph_wr = hit & hwrite;
        nxt_st.ph_addr = haddr[7:0];
        nxt_st.rdata = 32'h0;
        if (hit && !hwrite) begin
            if (haddr[7:0] == `LMR_OFF_CTRL) begin
                nxt_st.rdata = {25'h0, st_ff.ctrl};
            end else if (haddr[7:0] == `LMR_OFF_STAT) begin
                nxt_st.rdata = {23'h0, act, st_ff.src, st_ff.ifm,
                                st_ff.los};
            end
        end
        if (st_ff.ph_wr && st_ff.ph_addr == `LMR_OFF_CTRL) begin
            nxt_st.ctrl = hwdata[6:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_ff <= '0;
            st_ff.ctrl <= `LMR_CTRL_RST;
            st_ff.rdy <= 1'b1;
        end else if (hclk_en) begin
            st_ff <= nxt_st;
        end
    end

    assign hreadyout = st_ff.rdy;
    assign hresp = 1'b0 & st_ff.rdy;
    assign hrdata = st_ff.rdata;
    assign iface_mode = st_ff.ifm;
    assign tx_driver_float = st_ff.tx_flt;
    assign ds3_master_ref_o = st_ff.mref_o;
    assign e3_master_ref_o = st_ff.mref_o;
    assign sonet_master_ref_o = st_ff.mref_o;
    assign ds3_master_ref_oe = st_ff.mref_oe[0];
    assign e3_master_ref_oe = st_ff.mref_oe[1];
    assign sonet_master_ref_oe = st_ff.mref_oe[2];
    assign rx_clock_o = st_ff.rclk_o;
    assign rx_clock_oe = st_ff.rx_oe;
    assign rx_plus_or_data_o = st_ff.da_o;
    assign rx_plus_or_data_oe = st_ff.rx_oe;
    assign rx_minus_or_violation_o = st_ff.db_o;
    assign rx_minus_or_violation_oe = st_ff.rx_oe;
    assign rx_signal_absent_n_o = st_ff.los_n_o;
    assign rx_signal_absent_n_oe = st_ff.los_oe;

    // scan runs on its own pins and clock
    lmr_scan_tap u_tap (
        .scan_clock(scan_clock),
        .scan_reset_n(scan_reset_n),
        .scan_mode_sel(scan_mode_sel),
        .scan_in(scan_in),
        .scan_out(scan_out),
        .scan_out_oe(scan_out_oe)
    );

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence zero_bit;
        hclk_en && tick && !mark;
    endsequence

    sequence spi_straps;
        hclk_en && bus && !st_ff.s2.bus_style && !st_ff.s2.rd_n &&
        !st_ff.s2.wr_n && st_ff.s2.ale;
    endsequence

    pin_mode_refuse_a: assert property (
        hclk_en && !bus |=> !st_ff.ph_wr && st_ff.rdata == 32'h0)
        else $error("register access taken in pin mode");

    spi_select_a: assert property (
        spi_straps |=> st_ff.ifm == IF_SPI)
        else $error("serial bus not selected");

    par_default_a: assert property (
        hclk_en && bus && !(st_ff.s2.ale && !st_ff.s2.bus_style &&
        !st_ff.s2.rd_n && !st_ff.s2.wr_n) |=> st_ff.ifm == IF_PAR)
        else $error("parallel bus not default");

    float_all_a: assert property (
        hclk_en && !st_ff.s2.hiz_n |=> !st_ff.rx_oe && !st_ff.los_oe &&
        st_ff.mref_oe == 3'h0 && st_ff.tx_flt)
        else $error("output driven while globally floated");

    rx_float_a: assert property (
        hclk_en && (!st_ff.s2.rx_flt_n ||
        (bus && st_ff.ctrl[`LMR_C_RXFLT])) |=> !st_ff.rx_oe)
        else $error("receive outputs not floated");

    los_set_a: assert property (
        zero_bit ##0 (st_ff.zero_run == 8'd174) |=> st_ff.los)
        else $error("signal loss not raised after 175 zeros");

    los_hold_a: assert property (
        st_ff.los ##0 zero_bit ##0 exz |=>
        st_ff.los && st_ff.clear_run == 8'h0)
        else $error("signal loss cleared on excessive zeros");

    rclk_los_a: assert property (
        hclk_en && st_ff.los |=> st_ff.rclk_o == $past(mref))
        else $error("receive clock not from master ref during loss");

    exz_e3_a: assert property (
        zero_bit ##0 (rate == RATE_E3 && st_ff.zero_run == 8'd2) |=>
        st_ff.clear_run != 8'h0)
        else $error("three zeros taken as excessive in e3");

    ds3_high_a: assert property (
        hclk_en && rate == RATE_DS3 && !act[0] && refs[0] |=>
        st_ff.src == SRC_TX)
        else $error("held-high ds3 ref did not pick transmit clock");

    edge_flip_a: assert property (
        $changed(st_ff.da_o) |-> $past(upd))
        else $error("receive data moved off its clock edge");

    mref_pin_a: assert property (
        hclk_en && !bus |=> st_ff.mref_oe == 3'h0)
        else $error("master ref pin driven in pin mode");

endmodule

/* rtl/lmr_cfg.svh */
// offsets, field positions, reset values and counts of the liu control block
`ifndef LMR_CFG_SVH
`define LMR_CFG_SVH

// register byte offsets
`define LMR_OFF_CTRL 8'h00
`define LMR_OFF_STAT 8'h04

// control register fields, all active high
`define LMR_C_FLIP 0
`define LMR_C_NRZ 1
`define LMR_C_EURO 2
`define LMR_C_SONET 3
`define LMR_C_RXFLT 4
`define LMR_C_TXFLT 5
`define LMR_C_MDRV 6
`define LMR_CTRL_W 7
`define LMR_CTRL_RST 7'h00

// loss of signal thresholds in bit periods
`define LMR_LOS_SET 8'd175
`define LMR_LOS_CLR 8'd175

// excessive zero run lengths
`define LMR_EXZ_DS3 8'd3
`define LMR_EXZ_E3 8'd4

// reference activity window in hclk cycles
`define LMR_ACT_WIN 8'd16

`endif

/* rtl/lmr_pkg.sv */
// types of the liu control block
package lmr_pkg;

    typedef enum logic [1:0] {RATE_DS3, RATE_E3, RATE_STS} lmr_rate_t;
    typedef enum logic [1:0] {SRC_DS3, SRC_E3, SRC_STS, SRC_TX} lmr_src_t;
    typedef enum logic [1:0] {IF_PIN, IF_PAR, IF_SPI} lmr_if_t;

    typedef enum logic [3:0] {
        TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SH_DR, TAP_EX1_DR,
        TAP_PAUSE_DR, TAP_EX2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR,
        TAP_SH_IR, TAP_EX1_IR, TAP_PAUSE_IR, TAP_EX2_IR, TAP_UPD_IR
    } lmr_tap_t;

    typedef struct packed {
        lmr_tap_t state;
        logic [1:0] ir_sh;
        logic byp;
    } lmr_tap_st_t;

    typedef struct packed {
        logic mref_ds3, mref_e3, mref_sts, tx_clk, rx_clk, rx_pos, rx_neg;
        logic pin_cfg, bus_style, rd_n, wr_n, ale;
        logic euro, sonet, flip, nrz, rx_flt_n, tx_flt_n, hiz_n;
    } lmr_pins_t;

    typedef struct packed {
        lmr_pins_t s1, s2;
        logic [3:0] ref_prev;
        logic [3:0][7:0] act_cnt;
        logic rx_prev;
        logic [7:0] zero_run, clear_run;
        logic los, last_neg, bit_a, bit_b;
        logic [6:0] ctrl;
        logic ph_wr, rdy;
        logic [7:0] ph_addr;
        logic [31:0] rdata;
        lmr_if_t ifm;
        lmr_src_t src;
        logic rclk_o, da_o, db_o, rx_oe, los_n_o, los_oe, tx_flt, mref_o;
        logic [2:0] mref_oe;
    } lmr_st_t;

endpackage

/* rtl/lmr_scan_tap.sv */
// boundary-scan tap controller with a bypass data path
module lmr_scan_tap
    import lmr_pkg::*;
(
    // scan port
    input wire logic scan_clock,
    input wire logic scan_reset_n,
    input wire logic scan_mode_sel,
    input wire logic scan_in,
    output logic scan_out,
    output logic scan_out_oe
);

    lmr_tap_st_t st_ff, nxt_st;

    always_comb begin
        nxt_st = st_ff;
        case (st_ff.state)
            TAP_RESET: nxt_st.state = scan_mode_sel ? TAP_RESET : TAP_IDLE;
            TAP_IDLE: nxt_st.state = scan_mode_sel ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_DR: nxt_st.state = scan_mode_sel ? TAP_SEL_IR : TAP_CAP_DR;
            TAP_CAP_DR: nxt_st.state = scan_mode_sel ? TAP_EX1_DR : TAP_SH_DR;
            TAP_SH_DR: nxt_st.state = scan_mode_sel ? TAP_EX1_DR : TAP_SH_DR;
            TAP_EX1_DR: nxt_st.state = scan_mode_sel ? TAP_UPD_DR
                                                     : TAP_PAUSE_DR;
            TAP_PAUSE_DR: nxt_st.state = scan_mode_sel ? TAP_EX2_DR
                                                       : TAP_PAUSE_DR;
            TAP_EX2_DR: nxt_st.state = scan_mode_sel ? TAP_UPD_DR : TAP_SH_DR;
            TAP_UPD_DR: nxt_st.state = scan_mode_sel ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_IR: nxt_st.state = scan_mode_sel ? TAP_RESET : TAP_CAP_IR;
            TAP_CAP_IR: nxt_st.state = scan_mode_sel ? TAP_EX1_IR : TAP_SH_IR;
            TAP_SH_IR: nxt_st.state = scan_mode_sel ? TAP_EX1_IR : TAP_SH_IR;
            TAP_EX1_IR: nxt_st.state = scan_mode_sel ? TAP_UPD_IR
                                                     : TAP_PAUSE_IR;
            TAP_PAUSE_IR: nxt_st.state = scan_mode_sel ? TAP_EX2_IR
                                                       : TAP_PAUSE_IR;
            TAP_EX2_IR: nxt_st.state = scan_mode_sel ? TAP_UPD_IR : TAP_SH_IR;
            default: nxt_st.state = scan_mode_sel ? TAP_SEL_DR : TAP_IDLE;
        endcase
        // data shifts in on the rising edge
        if (st_ff.state == TAP_CAP_IR) begin
            nxt_st.ir_sh = 2'h1;
        end else if (st_ff.state == TAP_SH_IR) begin
            nxt_st.ir_sh = {scan_in, st_ff.ir_sh[1]};
        end
        if (st_ff.state == TAP_CAP_DR) begin
            nxt_st.byp = 1'b0;
        end else if (st_ff.state == TAP_SH_DR) begin
            nxt_st.byp = scan_in;
        end
    end

    // mode select sampled on rising edges, reset without the clock
    always_ff @(posedge scan_clock or negedge scan_reset_n) begin
        if (!scan_reset_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // data leaves on the falling edge so the far end samples it mid-bit
    always_ff @(negedge scan_clock or negedge scan_reset_n) begin
        if (!scan_reset_n) begin
            scan_out <= 1'b0;
            scan_out_oe <= 1'b0;
        end else begin
            scan_out <= (st_ff.state == TAP_SH_IR) ? st_ff.ir_sh[0]
                                                   : st_ff.byp;
            scan_out_oe <= (st_ff.state == TAP_SH_IR) ||
                           (st_ff.state == TAP_SH_DR);
        end
    end

endmodule

/* tb/lmr_line_model.sv */
// line source model: recovered clock and bipolar line pulses
module lmr_line_model (
    // clock and pattern: 0 zeros, 1 alternate marks, 2 plus only, 3 sparse
    input wire logic hclk,
    input wire logic [1:0] pat,
    // line side
    output logic rx_rec_clock,
    output logic rx_line_plus,
    output logic rx_line_minus
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0] ph_ff = 3'h0;
    logic [1:0] idx_ff = 2'h0;
    logic pol_ff = 1'b0;
    logic mark;
    initial {rx_rec_clock, rx_line_plus, rx_line_minus} = 3'h0;
    // eight hclk a bit keeps the clock below hclk/4; lines move while low
    always @(posedge hclk) begin
        ph_ff <= ph_ff + 3'h1;
        rx_rec_clock <= ph_ff[2];
        if (ph_ff == 3'h1) begin
            mark = pat[0] ? (pat[1] ? idx_ff == 2'h0 : 1'b1) : pat[1];
            idx_ff <= idx_ff + 2'h1;
            pol_ff <= pol_ff ^ mark;
            rx_line_plus <= mark && (pat == 2'h2 || !pol_ff);
            rx_line_minus <= mark && pat != 2'h2 && pol_ff;
        end
    end
endmodule

/* tb/lmr_liu_ctrl_tb_top.sv */
// self-checking bench of the liu control block
module lmr_liu_ctrl_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic hclk, hresetn, hclk_en, hsel, hwrite, hready, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans, iface_mode, pat;
    logic [2:0] hsize;
    logic pin_config_select, bus_style_select, rd_strobe_n, wr_strobe_n;
    logic addr_latch_en, european_rate_select, sonet_rate_select;
    logic rx_edge_flip, rx_nrz_select, rx_float_n, tx_driver_float_n;
    logic all_outputs_float_n, tx_driver_float, tx_line_clock;
    logic ds3_master_ref_i, ds3_master_ref_o, ds3_master_ref_oe;
    logic e3_master_ref_i, e3_master_ref_o, e3_master_ref_oe;
    logic sonet_master_ref_i, sonet_master_ref_o, sonet_master_ref_oe;
    logic rx_rec_clock, rx_line_plus, rx_line_minus, rx_clock_o;
    logic rx_clock_oe, rx_plus_or_data_o, rx_plus_or_data_oe;
    logic rx_minus_or_violation_o, rx_minus_or_violation_oe;
    logic rx_signal_absent_n_o, rx_signal_absent_n_oe;
    logic scan_clock, scan_reset_n, scan_mode_sel, scan_in;
    logic scan_out, scan_out_oe;
    logic [3:0] tog, lvl, drv;
    logic [15:0] tbl [13];
    int err_total, tests_run, n_p, n_m, dp, dm;

    lmr_liu_ctrl u_lmr_liu_ctrl (.*);
    lmr_line_model u_lmr_line_model (.*);

    assign hready = hreadyout;
    assign tx_line_clock = drv[3];
    // an idle ref pin may be driven by the block, so resolve each wire
    assign ds3_master_ref_i = ds3_master_ref_oe ? ds3_master_ref_o : drv[0];
    assign e3_master_ref_i = e3_master_ref_oe ? e3_master_ref_o : drv[1];
    assign sonet_master_ref_i = sonet_master_ref_oe ? sonet_master_ref_o
                                                    : drv[2];

    always @(posedge hclk) begin
        drv <= (tog & ~drv) | (~tog & lvl);
        n_p <= n_p + int'(rx_plus_or_data_o === 1'b1);
        n_m <= n_m + int'(rx_minus_or_violation_o === 1'b1);
    end

    initial begin
        hclk = 1'b0;
        forever #50 hclk = ~hclk;
    end

    task automatic conclude;
        if (err_total == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, exp, input string what);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: %s got %h", $time, what, got);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge hclk);
    endtask

    // zero wait is expected, but the wait stays bounded
    task automatic wait_rdy;
        int n;
        n = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1 && n < 50) begin
            n++;
            @(posedge hclk);
        end
        if (n == 50) begin
            chk(0, 1, "bus hang");
            conclude;
        end
    endtask

    task automatic xfer(input logic w, input logic [31:0] a, wd,
                        output logic [31:0] rd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        wait_rdy;
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_rdy;
        rd = hrdata;
    endtask

    task automatic wr(input logic [31:0] a, wd);
        logic [31:0] rd;
        xfer(1'b1, a, wd, rd);
    endtask

    task automatic rdchk(input logic [31:0] a, m, exp, input string what);
        logic [31:0] rd;
        xfer(1'b0, a, 32'h0, rd);
        chk(rd & m, exp, what);
    endtask

    task automatic wait_los(input logic v, input int lim);
        int n;
        n = 0;
        while (rx_signal_absent_n_o !== v && n < lim) begin
            n++;
            @(posedge hclk);
        end
        chk(rx_signal_absent_n_o, v, "loss time");
    endtask

    // counts plus and minus pulses over eighty cycles of settled traffic
    task automatic rx_run(input logic [31:0] c, input logic [1:0] p);
        int a, b;
        wr(32'h0, c);
        pat <= p;
        cyc(40);
        a = n_p;
        b = n_m;
        cyc(80);
        dp = n_p - a;
        dm = n_m - b;
    endtask

    task automatic scan_step(input logic tms);
        scan_mode_sel <= tms;
        cyc(1);
        scan_clock <= 1'b1;
        cyc(1);
        scan_clock <= 1'b0;
        cyc(1);
    endtask

    initial begin
        cyc(60000);
        chk(0, 1, "run hang");
        conclude;
    end

    initial begin
        {hresetn, hsel, hwrite, haddr, hwdata, htrans, lvl, drv} = '0;
        {pin_config_select, european_rate_select, sonet_rate_select} = '0;
        {rx_edge_flip, rx_nrz_select, scan_clock, scan_reset_n} = '0;
        {hclk_en, bus_style_select, rd_strobe_n, wr_strobe_n} = '1;
        {addr_latch_en, rx_float_n, tx_driver_float_n, scan_in} = '1;
        {all_outputs_float_n, scan_mode_sel} = '1;
        hsize = 3'h2;
        pat = 2'h1;
        tog = 4'h8;
        tbl = '{16'h0a01, 16'h0e01, 16'h0c02, 16'h0a13, 16'h0900, 16'h0803,
                16'h4d00, 16'h4c02, 16'h4a01, 16'hcb00, 16'hca01, 16'hca43,
                16'hc803};
        cyc(2);
        chk({hreadyout, hresp}, 2'b10, "reset bus");
        cyc(2);
        hresetn <= 1'b1;
        cyc(20);
        chk(iface_mode, 32'h1, "parallel");
        rdchk(32'h0, '1, 32'h0, "ctrl reset");
        rdchk(32'h4, '1, 32'h11a, "status reset");
        wr(32'h0, '1);
        rdchk(32'h0, '1, 32'h7f, "ctrl width");
        rdchk(32'h8, '1, 32'h0, "unmapped");
        wr(32'h0, 32'h30);
        cyc(3);
        chk({tx_driver_float, rx_clock_oe}, 2'b10, "float bits");
        wr(32'h0, 32'h0);
        {tx_driver_float_n, rx_float_n} <= 2'b00;
        cyc(6);
        chk({tx_driver_float, rx_clock_oe}, 2'b10, "float pins");
        {tx_driver_float_n, rx_float_n} <= 2'b11;
        cyc(6);
        chk({tx_driver_float, rx_clock_oe}, 2'b01, "float off");
        {bus_style_select, rd_strobe_n, wr_strobe_n} <= 3'b000;
        cyc(6);
        chk(iface_mode, 32'h2, "serial");
        addr_latch_en <= 1'b0;
        cyc(6);
        chk(iface_mode, 32'h1, "latch low");
        {bus_style_select, rd_strobe_n, wr_strobe_n, addr_latch_en} <= '1;
        foreach (tbl[i]) begin
            wr(32'h0, {28'h0, tbl[i][15:12]});
            tog <= tbl[i][11:8];
            lvl <= tbl[i][7:4];
            cyc(50);
            rdchk(32'h4, 32'h18, {tbl[i][1:0], 3'h0},
                  "src");
        end
        rx_run(32'h0, 2'h1);
        chk({dp > 0, dm > 0}, 2'b11, "ami");
        rx_run(32'h0, 2'h2);
        chk({dp > 0, dm > 0}, 2'b10, "plus only");
        rx_run(32'h2, 2'h2);
        chk({dp > 0, dm > 0}, 2'b11, "violation");
        rx_run(32'h2, 2'h1);
        chk({dp > 0, dm > 0}, 2'b10, "clean data");
        rx_run(32'h3, 2'h2);
        chk({dp > 0, dm > 0}, 2'b11, "flipped");
        wr(32'h0, 32'h0);
        pat <= 2'h0;
        cyc(1300);
        chk(rx_signal_absent_n_o, 1, "early loss");
        wait_los(1'b0, 400);
        chk(rx_signal_absent_n_oe, 1, "loss pin");
        rdchk(32'h4, 32'h1, 32'h1, "loss bit");
        pat <= 2'h3;
        cyc(1800);
        chk(rx_signal_absent_n_o, 0, "three zeros");
        wr(32'h0, 32'h4);
        cyc(1300);
        chk(rx_signal_absent_n_o, 0, "early clear");
        wait_los(1'b1, 400);
        hclk_en <= 1'b0;
        pin_config_select <= 1'b1;
        cyc(6);
        chk(iface_mode, 32'h1, "frozen");
        hclk_en <= 1'b1;
        pin_config_select <= 1'b1;
        cyc(6);
        chk(iface_mode, 32'h0, "pin mode");
        wr(32'h0, 32'h1);
        rdchk(32'h0, '1, 32'h0, "refused");
        scan_reset_n <= 1'b1;
        cyc(1);
        for (int i = 0; i < 4; i++) scan_step(i == 1);
        chk(scan_out_oe, 1, "scan shift");
        scan_reset_n <= 1'b0;
        cyc(1);
        chk(scan_out_oe, 0, "scan reset");
        all_outputs_float_n <= 1'b0;
        cyc(6);
        chk({rx_clock_oe, tx_driver_float}, 2'b01, "all float");
        conclude;
    end
endmodule
